// ==== core/msm_ctrl.sv ====
// magnet switch mode controller: menu sequencing, display, loop current, status port
`timescale 1ns/100ps
`include "msm_cfg.svh"
module msm_ctrl #(
    parameter int          READ_W      = 12,
    parameter logic [31:0] TICK_CYCLES = `MSM_TICK_CYCLES
) (
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 reset,
    // magnetic switches
    input  wire logic                 magnet_switch_left,
    input  wire logic                 magnet_switch_right,
    // measurement side
    input  wire logic [READ_W-1:0]    reading,
    input  wire logic [7:0]           sensor_faults,
    input  wire logic                 cal_fault_set,
    input  wire logic                 span_done,
    // parallel status port
    input  wire logic [3:0]           bus_addr,
    input  wire logic [15:0]          bus_wdata,
    input  wire logic                 bus_write,
    input  wire logic                 bus_read,
    output logic      [15:0]          bus_rdata,
    // readout module
    output logic                      arrow_left,
    output logic                      arrow_right,
    output msm_pkg::msm_msg_type      display_msg,
    output logic      [2:0]           display_item,
    output logic      [READ_W-1:0]    display_value,
    // analog side
    output logic      [15:0]          loop_ua,
    output logic                      in_calibration,
    output logic                      zero_cal_active,
    output logic                      span_cal_active
);
    msm_sw_if sw_left ();
    msm_sw_if sw_right ();

    logic        tick_reg, tick_next;
    logic [31:0] presc_reg, presc_next;

    msm_switch u_left (
        .clk        (clk),
        .reset      (reset),
        .tick       (tick_reg),
        .switch_raw (magnet_switch_left),
        .sw         (sw_left.sense)
    );

    msm_switch u_right (
        .clk        (clk),
        .reset      (reset),
        .tick       (tick_reg),
        .switch_raw (magnet_switch_right),
        .sw         (sw_right.sense)
    );

    // one shared millisecond tick keeps every timer a small counter
    always_comb begin
        tick_next  = 1'b0;
        presc_next = presc_reg + 32'h1;
        if (presc_reg >= TICK_CYCLES - 32'h1) begin
            presc_next = 32'h0;
            tick_next  = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            presc_reg <= 32'h0;
            tick_reg  <= 1'b0;
        end else begin
            presc_reg <= presc_next;
            tick_reg  <= tick_next;
        end
    end

    // menu state
    msm_pkg::msm_state_type state_reg, state_next;
    msm_pkg::msm_msg_type   msg_reg, msg_next;
    logic [31:0]            timer_reg, timer_next;
    logic [31:0]            minute_reg, minute_next;
    logic [2:0]             count_reg, count_next;
    logic [2:0]             item_reg, item_next;
    logic                   cal_fault_reg, cal_fault_next;
    logic                   force_normal;
    logic                   clear_fault;
    logic                   any_fault;
    logic                   activity;

    assign force_normal = bus_write && bus_addr == `MSM_ADDR_CONTROL
                          && bus_wdata[`MSM_CTRL_FORCE_NORMAL];
    assign clear_fault  = bus_write && bus_addr == `MSM_ADDR_CONTROL
                          && bus_wdata[`MSM_CTRL_CLR_CAL_FAULT];
    assign any_fault    = (|sensor_faults) || cal_fault_reg;
    assign activity     = sw_left.active || sw_right.active || sw_left.touch || sw_right.touch;

    always_comb begin
        state_next  = state_reg;
        timer_next  = timer_reg + {31'h0, tick_reg};
        minute_next = 32'h0;
        count_next  = count_reg;
        item_next   = item_reg;
        msg_next    = msm_pkg::MSG_READING;
        // a fault that arrives together with the clear stays set
        cal_fault_next = cal_fault_set ? 1'b1 : (clear_fault ? 1'b0 : cal_fault_reg);
        case (state_reg)
            msm_pkg::ST_NORMAL: begin
                minute_next = minute_reg + {31'h0, tick_reg};
                if (minute_reg >= `MSM_FLASH_PERIOD_MS - 1) begin
                    minute_next = 32'h0;
                end
                if (minute_reg < `MSM_FLASH_MS) begin
                    msg_next = any_fault ? msm_pkg::MSG_FAULT_DETECTED
                                         : msm_pkg::MSG_UNITS_GAS;
                end
                if (sw_left.hold_short) begin
                    state_next = msm_pkg::ST_CAL_PROMPT;
                end else if (sw_right.hold_short) begin
                    state_next = msm_pkg::ST_PROG_SCROLL;
                    item_next  = 3'h0;
                    count_next = 3'h0;
                end else if ((sw_left.touch || sw_right.touch) && any_fault) begin
                    state_next = msm_pkg::ST_FAULT_LIST;
                end
            end
            msm_pkg::ST_FAULT_LIST: begin
                msg_next = msm_pkg::MSG_FAULT_LIST;
                if (timer_reg >= `MSM_SCROLL_MS) begin
                    state_next = msm_pkg::ST_NORMAL;
                end
            end
            msm_pkg::ST_CAL_PROMPT: begin
                msg_next = msm_pkg::MSG_CAL_PROMPT;
                if (sw_left.hold_short) begin
                    state_next = msm_pkg::ST_ZERO_CAL;
                    count_next = 3'h0;
                end else if (sw_right.hold_short) begin
                    state_next = msm_pkg::ST_SPAN_CAL;
                end else if (timer_reg >= `MSM_CAL_PROMPT_MS) begin
                    state_next = msm_pkg::ST_NORMAL;
                end
            end
            msm_pkg::ST_ZERO_CAL: begin
                // two scrolls per message, three messages in order
                case (count_reg[2:1])
                    2'h0:    msg_next = msm_pkg::MSG_ZERO_CAL;
                    2'h1:    msg_next = msm_pkg::MSG_SETTING_ZERO;
                    default: msg_next = msm_pkg::MSG_ZERO_SAVED;
                endcase
                if (timer_reg >= `MSM_SCROLL_MS) begin
                    timer_next = 32'h0;
                    count_next = count_reg + 3'h1;
                    if (count_reg == 3'(`MSM_ZERO_SCROLLS * `MSM_ZERO_MESSAGES - 1)) begin
                        state_next = msm_pkg::ST_NORMAL;
                    end
                end
            end
            msm_pkg::ST_SPAN_CAL: begin
                msg_next = msm_pkg::MSG_SPAN_CAL;
                if (span_done) begin
                    state_next = msm_pkg::ST_NORMAL;
                end
            end
            msm_pkg::ST_PROG_SCROLL: begin
                msg_next = msm_pkg::MSG_MENU_ITEM;
                if (sw_left.hold_short) begin
                    state_next = msm_pkg::ST_PROG_EDIT;
                end else if (sw_right.touch || sw_left.touch) begin
                    timer_next = 32'h0;
                    count_next = 3'h0;
                    item_next  = sw_right.touch ? item_reg + 3'h1 : item_reg - 3'h1;
                end else if (sw_left.active || sw_right.active) begin
                    count_next = 3'h0;
                end else if (timer_reg >= `MSM_SCROLL_MS) begin
                    timer_next = 32'h0;
                    item_next  = item_reg + 3'h1;
                    count_next = count_reg + 3'h1;
                    if (count_reg == 3'(`MSM_PROG_IDLE_SCROLLS - 1)) begin
                        state_next = msm_pkg::ST_NORMAL;
                    end
                end
            end
            msm_pkg::ST_PROG_EDIT: begin
                msg_next = msm_pkg::MSG_EDIT_ITEM;
                if (activity) begin
                    timer_next = 32'h0;
                end
                if (sw_left.hold_short) begin
                    state_next = msm_pkg::ST_PROG_SCROLL;
                    count_next = 3'h0;
                end else if (timer_reg >= `MSM_EDIT_IDLE_MS
                             && item_reg != 3'(`MSM_SIGNAL_CHECK_ITEM)) begin
                    state_next = msm_pkg::ST_PROG_SCROLL;
                    count_next = 3'h0;
                end
            end
            default: begin
                state_next = msm_pkg::ST_NORMAL;
            end
        endcase
        // a declared calibration fault aborts a zero or span calibration in progress; the calibration prompt is left running
        if (force_normal || (cal_fault_set && (state_reg == msm_pkg::ST_ZERO_CAL
                                               || state_reg == msm_pkg::ST_SPAN_CAL))) begin
            state_next = msm_pkg::ST_NORMAL;
        end
        if (state_next != state_reg) begin
            timer_next  = 32'h0;
            minute_next = 32'h0;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_reg     <= msm_pkg::ST_NORMAL;
            msg_reg       <= msm_pkg::MSG_READING;
            timer_reg     <= 32'h0;
            minute_reg    <= 32'h0;
            count_reg     <= 3'h0;
            item_reg      <= 3'h0;
            cal_fault_reg <= 1'b0;
        end else begin
            state_reg     <= state_next;
            msg_reg       <= msg_next;
            timer_reg     <= timer_next;
            minute_reg    <= minute_next;
            count_reg     <= count_next;
            item_reg      <= item_next;
            cal_fault_reg <= cal_fault_next;
        end
    end

    // loop current, warm-up hold and status bits
    logic [31:0] warm_reg, warm_next;
    logic [15:0] loop_reg, loop_next;
    logic        in_cal_reg, in_cal_next;
    logic        zero_reg, span_reg;
    logic [31:0] scaled;

    assign scaled = (32'(reading) * 32'(`MSM_LOOP_SPAN_UA)) >> READ_W;

    always_comb begin
        in_cal_next = state_next == msm_pkg::ST_CAL_PROMPT
                      || state_next == msm_pkg::ST_ZERO_CAL
                      || state_next == msm_pkg::ST_SPAN_CAL;
        warm_next = warm_reg;
        if (warm_reg < `MSM_WARMUP_MS) begin
            warm_next = warm_reg + {31'h0, tick_reg};
        end
        // calibration fault beats calibration beats warm-up
        if (cal_fault_next) begin
            loop_next = 16'(`MSM_LOOP_FAULT_UA);
        end else if (in_cal_next) begin
            loop_next = 16'(`MSM_LOOP_CAL_UA);
        end else if (warm_reg < `MSM_WARMUP_MS) begin
            loop_next = 16'(`MSM_LOOP_ZERO_UA);
        end else begin
            loop_next = 16'(32'(`MSM_LOOP_ZERO_UA) + scaled);
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            warm_reg   <= 32'h0;
            loop_reg   <= 16'(`MSM_LOOP_ZERO_UA);
            in_cal_reg <= 1'b0;
            zero_reg   <= 1'b0;
            span_reg   <= 1'b0;
        end else begin
            warm_reg   <= warm_next;
            loop_reg   <= loop_next;
            in_cal_reg <= in_cal_next;
            zero_reg   <= state_next == msm_pkg::ST_ZERO_CAL;
            span_reg   <= state_next == msm_pkg::ST_SPAN_CAL;
        end
    end

    // polled status port, answered the cycle after the read strobe
    logic [15:0] status_word;
    logic [15:0] rdata_reg, rdata_next;
    logic [READ_W-1:0] value_reg;

    always_comb begin
        status_word = 16'h0;
        status_word[`MSM_STAT_FAULT_W-1:0]  = sensor_faults;
        status_word[`MSM_STAT_CAL_FAULT_BIT] = cal_fault_reg;
        status_word[`MSM_STAT_CAL_BIT]       = in_cal_reg;
        rdata_next = 16'h0;
        if (bus_read) begin
            case (bus_addr)
                `MSM_ADDR_READING: rdata_next = 16'(reading);
                `MSM_ADDR_STATUS:  rdata_next = status_word;
                default:           rdata_next = 16'h0;
            endcase
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rdata_reg <= 16'h0;
            value_reg <= '0;
        end else begin
            rdata_reg <= rdata_next;
            value_reg <= reading;
        end
    end

    assign bus_rdata       = rdata_reg;
    assign arrow_left      = sw_left.active;
    assign arrow_right     = sw_right.active;
    assign display_msg     = msg_reg;
    assign display_item    = item_reg;
    assign display_value   = value_reg;
    assign loop_ua         = loop_reg;
    assign in_calibration  = in_cal_reg;
    assign zero_cal_active = zero_reg;
    assign span_cal_active = span_reg;

endmodule : msm_ctrl

// ==== core/msm_cfg.svh ====
// timing counts, register offsets and field positions of the magnet switch mode controller
`ifndef MSM_CFG_SVH
`define MSM_CFG_SVH

// clock and the 1 ms timing tick
`define MSM_CLK_PERIOD_PS   5000
`define MSM_TICK_PS         1000000000
`define MSM_TICK_CYCLES     (`MSM_TICK_PS / `MSM_CLK_PERIOD_PS)

// times in 1 ms ticks
`define MSM_DEBOUNCE_MS     20
`define MSM_HOLD_SHORT_MS   3000
`define MSM_HOLD_LONG_MS    10000
`define MSM_CAL_PROMPT_MS   5000
`define MSM_EDIT_IDLE_MS    3500
`define MSM_FLASH_PERIOD_MS 60000
`define MSM_FLASH_MS        2000
`define MSM_SCROLL_MS       2000
`define MSM_WARMUP_MS       120000

// menu figures
`define MSM_PROG_IDLE_SCROLLS 4
`define MSM_ZERO_SCROLLS      2
`define MSM_ZERO_MESSAGES     3
`define MSM_MENU_ITEMS        8
`define MSM_SIGNAL_CHECK_ITEM 6

// loop current levels in microamps
`define MSM_LOOP_FAULT_UA   0
`define MSM_LOOP_CAL_UA     2000
`define MSM_LOOP_ZERO_UA    4000
`define MSM_LOOP_SPAN_UA    16000

// register offsets
`define MSM_ADDR_READING    4'h0
`define MSM_ADDR_STATUS     4'h1
`define MSM_ADDR_CONTROL    4'h2

// status word fields
`define MSM_STAT_CAL_BIT       14
`define MSM_STAT_CAL_FAULT_BIT 8
`define MSM_STAT_FAULT_W       8

// control write bits, both act as one-shot commands
`define MSM_CTRL_CLR_CAL_FAULT 0
`define MSM_CTRL_FORCE_NORMAL  1

`endif

// ==== core/msm_pkg.sv ====
// types of the magnet switch mode controller
package msm_pkg;

    typedef enum logic [3:0] {
        MSG_READING,
        MSG_UNITS_GAS,
        MSG_FAULT_DETECTED,
        MSG_FAULT_LIST,
        MSG_CAL_PROMPT,
        MSG_ZERO_CAL,
        MSG_SETTING_ZERO,
        MSG_ZERO_SAVED,
        MSG_SPAN_CAL,
        MSG_MENU_ITEM,
        MSG_EDIT_ITEM
    } msm_msg_type;

    typedef enum logic [2:0] {
        ST_NORMAL,
        ST_FAULT_LIST,
        ST_CAL_PROMPT,
        ST_ZERO_CAL,
        ST_SPAN_CAL,
        ST_PROG_SCROLL,
        ST_PROG_EDIT
    } msm_state_type;

endpackage : msm_pkg

// ==== core/msm_sw_if.sv ====
// classified events of one magnetic switch
`timescale 1ns/100ps
interface msm_sw_if;
    logic active;
    logic touch;
    logic hold_short;
    logic hold_long;

    modport sense (output active, output touch, output hold_short, output hold_long);
    modport sink  (input active, input touch, input hold_short, input hold_long);
endinterface : msm_sw_if

// ==== core/msm_switch.sv ====
// synchroniser, debouncer and hold classifier for one magnetic switch
`timescale 1ns/100ps
`include "msm_cfg.svh"
module msm_switch #(
    parameter logic [31:0] DEB_MS   = `MSM_DEBOUNCE_MS,
    parameter logic [31:0] SHORT_MS = `MSM_HOLD_SHORT_MS,
    parameter logic [31:0] LONG_MS  = `MSM_HOLD_LONG_MS
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic reset,
    // 1 ms tick and raw switch
    input  wire logic tick,
    input  wire logic switch_raw,
    // classified events
    msm_sw_if.sense   sw
);
    logic        sync1_reg, sync2_reg;
    logic        stable_reg, stable_next;
    logic [31:0] deb_reg, deb_next;
    logic [31:0] hold_reg, hold_next;
    logic        short_done_reg, short_done_next;
    logic        touch_reg, touch_next;
    logic        hs_reg, hs_next;
    logic        hl_reg, hl_next;

    always_comb begin
        stable_next     = stable_reg;
        deb_next        = 32'h0;
        hold_next       = hold_reg;
        short_done_next = short_done_reg;
        touch_next      = 1'b0;
        hs_next         = 1'b0;
        hl_next         = 1'b0;
        // a level must stay changed for the whole window, so a glitch restarts it
        if (sync2_reg != stable_reg) begin
            deb_next = deb_reg;
            if (tick) begin
                if (deb_reg >= DEB_MS - 32'h1) begin
                    stable_next = sync2_reg;
                    deb_next    = 32'h0;
                end else begin
                    deb_next = deb_reg + 32'h1;
                end
            end
        end
        if (!stable_reg) begin
            hold_next       = 32'h0;
            short_done_next = 1'b0;
        end else if (tick && hold_reg < LONG_MS) begin
            // timing starts with the arrow, i.e. the debounced level
            hold_next = hold_reg + 32'h1;
            if (hold_reg == SHORT_MS - 32'h1) begin
                hs_next         = 1'b1;
                short_done_next = 1'b1;
            end
            if (hold_reg == LONG_MS - 32'h1) begin
                hl_next = 1'b1;
            end
        end
        if (stable_reg && !stable_next && !short_done_reg) begin
            touch_next = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sync1_reg      <= 1'b0;
            sync2_reg      <= 1'b0;
            stable_reg     <= 1'b0;
            deb_reg        <= 32'h0;
            hold_reg       <= 32'h0;
            short_done_reg <= 1'b0;
            touch_reg      <= 1'b0;
            hs_reg         <= 1'b0;
            hl_reg         <= 1'b0;
        end else begin
            sync1_reg      <= switch_raw;
            sync2_reg      <= sync1_reg;
            stable_reg     <= stable_next;
            deb_reg        <= deb_next;
            hold_reg       <= hold_next;
            short_done_reg <= short_done_next;
            touch_reg      <= touch_next;
            hs_reg         <= hs_next;
            hl_reg         <= hl_next;
        end
    end

    assign sw.active     = stable_reg;
    assign sw.touch      = touch_reg;
    assign sw.hold_short = hs_reg;
    assign sw.hold_long  = hl_reg;

endmodule : msm_switch

// ==== test/msm_ctrl_asserts.sv ====
// concurrent checks on the mode controller ports
`timescale 1ns/100ps
`include "msm_cfg.svh"
module msm_ctrl_asserts #(
    parameter int          READ_W      = 12,
    parameter logic [31:0] TICK_CYCLES = 4
) (
    // clock and reset
    input wire logic                 clk,
    input wire logic                 reset,
    // inputs watched
    input wire logic                 magnet_switch_left,
    input wire logic [READ_W-1:0]    reading,
    input wire logic                 cal_fault_set,
    input wire logic [3:0]           bus_addr,
    input wire logic [15:0]          bus_wdata,
    input wire logic                 bus_write,
    input wire logic                 bus_read,
    // outputs watched
    input wire logic [15:0]          bus_rdata,
    input wire logic                 arrow_left,
    input wire msm_pkg::msm_msg_type display_msg,
    input wire logic [15:0]          loop_ua,
    input wire logic                 in_calibration,
    input wire logic                 zero_cal_active,
    input wire logic                 span_cal_active
);
    localparam int HOLD_C = `MSM_HOLD_SHORT_MS * TICK_CYCLES;
    localparam int DEB_C  = (`MSM_DEBOUNCE_MS - 1) * TICK_CYCLES;
    localparam int PRM_C  = `MSM_CAL_PROMPT_MS * TICK_CYCLES + 8;
    int   raw_cnt_reg;
    int   arw_cnt_reg;
    int   prm_cnt_reg;
    logic flt_reg;

    // mirror of the sticky calibration fault, since status is only seen on reads
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            raw_cnt_reg <= 0;
            arw_cnt_reg <= 0;
            prm_cnt_reg <= 0;
            flt_reg     <= 1'b0;
        end else begin
            raw_cnt_reg <= magnet_switch_left ? raw_cnt_reg + 1 : 0;
            arw_cnt_reg <= arrow_left ? arw_cnt_reg + 1 : 0;
            prm_cnt_reg <= (in_calibration && !zero_cal_active && !span_cal_active) ?
                           prm_cnt_reg + 1 : 0;
            if (cal_fault_set)
                flt_reg <= 1'b1;
            else if (bus_write && bus_addr == 4'h2 && bus_wdata[0])
                flt_reg <= 1'b0;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    chk_hold_from_arrow: assert property ($rose(in_calibration) |->
        arw_cnt_reg >= HOLD_C - 6 && arw_cnt_reg <= HOLD_C + 6) else $error("hold time off");
    chk_debounce_left: assert property ($rose(arrow_left) |-> raw_cnt_reg >= DEB_C)
        else $error("arrow rose before debounce");
    chk_cal_loop: assert property ((in_calibration && !flt_reg)[*3] |-> loop_ua == 16'h07d0)
        else $error("loop not at calibration level");
    chk_cal_status: assert property (bus_read && bus_addr == 4'h1 |=>
        bus_rdata[14] == $past(in_calibration)) else $error("status bit 14 wrong");
    chk_read_value: assert property (bus_read && bus_addr == 4'h0 |=>
        bus_rdata == 16'($past(reading))) else $error("reading word wrong");
    chk_rdata_idle: assert property (!bus_read |=> bus_rdata == 16'h0000)
        else $error("read data outside read slot");
    chk_fault_zero: assert property (cal_fault_set && (zero_cal_active || span_cal_active)
        |-> ##[1:3] loop_ua == 16'h0000) else $error("fault did not drop loop");
    // the message register trails the state outputs by one cycle
    chk_prompt_state: assert property (display_msg == msm_pkg::MSG_CAL_PROMPT |->
        $past(in_calibration) && !$past(zero_cal_active) && !$past(span_cal_active))
        else $error("prompt outside cal");
    chk_sub_in_cal: assert property ((zero_cal_active || span_cal_active) |->
        in_calibration && !(zero_cal_active && span_cal_active)) else $error("bad cal substate");
    chk_prompt_timeout: assert property (prm_cnt_reg <= PRM_C)
        else $error("prompt outlived its timeout");

    cov_cal_entry: cover property ($rose(in_calibration));
    cov_cal_exit: cover property ($fell(in_calibration));
    cov_span: cover property ($rose(span_cal_active));
endmodule : msm_ctrl_asserts

// ==== test/msm_operator.sv ====
// magnet operator: holds one switch for a number of timing ticks
`timescale 1ns/100ps
module msm_operator #(
    parameter int TICK_CYCLES = 4
) (
    // clock
    input  wire logic clk,
    // switch levels
    output logic      sw_left,
    output logic      sw_right
);
    initial begin
        sw_left  = 1'b0;
        sw_right = 1'b0;
    end

    // one magnet only; the gap after release lets the debouncer settle
    task automatic hold(input bit right, input int ticks);
        @(posedge clk);
        if (right)
            sw_right <= 1'b1;
        else
            sw_left <= 1'b1;
        repeat (ticks * TICK_CYCLES) @(posedge clk);
        sw_left  <= 1'b0;
        sw_right <= 1'b0;
        repeat (40 * TICK_CYCLES) @(posedge clk);
        #1;
    endtask : hold
endmodule : msm_operator

// ==== test/msm_ctrl_tb.sv ====
// self-checking bench of the magnet switch mode controller
`timescale 1ns/100ps
module msm_ctrl_tb;
    // one tick per cycle keeps the long menu runs inside the cycle budget
    localparam int TC = 1;
    logic clk, reset, sw_l, sw_r, cal_fault_set, span_done, bus_write, bus_read;
    logic [11:0] reading, dval;
    logic [2:0]  item;
    logic [7:0]  sensor_faults;
    logic [3:0]  bus_addr;
    logic [15:0] bus_wdata, bus_rdata, loop_ua;
    logic        arrow_l, arrow_r, in_cal, zero_act, span_act;
    msm_pkg::msm_msg_type msg;
    int          err_count, check_count, cyc;

    msm_ctrl #(.READ_W(12), .TICK_CYCLES(TC)) dut (.clk(clk), .reset(reset),
        .magnet_switch_left(sw_l), .magnet_switch_right(sw_r), .reading(reading),
        .sensor_faults(sensor_faults), .cal_fault_set(cal_fault_set), .span_done(span_done),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_write(bus_write), .bus_read(bus_read),
        .bus_rdata(bus_rdata), .arrow_left(arrow_l), .arrow_right(arrow_r), .display_msg(msg),
        .display_item(item), .display_value(dval), .loop_ua(loop_ua), .in_calibration(in_cal),
        .zero_cal_active(zero_act), .span_cal_active(span_act));
    msm_operator #(.TICK_CYCLES(TC)) op (.clk(clk), .sw_left(sw_l), .sw_right(sw_r));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // the master starts every transfer
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        bus_addr  <= a;
        bus_wdata <= d;
        bus_write <= 1'b1;
        @(posedge clk);
        bus_write <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge clk);
        bus_addr <= a;
        bus_read <= 1'b1;
        @(posedge clk);
        bus_read <= 1'b0;
        #1;
        check(bus_rdata, exp);
    endtask : rd

    task automatic ticks(input int n);
        repeat (n * TC) @(posedge clk);
        #1;
    endtask : ticks

    task automatic wrap_up();
        $display("mismatches %0d comparisons %0d", err_count, check_count);
        if (err_count == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : wrap_up

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // a hang counts as a mismatch
    always @(posedge clk) begin
        cyc++;
        if (cyc == 90000) begin
            err_count++;
            wrap_up();
        end
    end

    initial begin
        reset = 1'b1;
        reading = 12'h800;
        sensor_faults = 8'h00;
        {cal_fault_set, span_done, bus_write, bus_read} = 4'h0;
        bus_addr = 4'h0;
        bus_wdata = 16'h0000;
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        ticks(100);
        check(msg, msm_pkg::MSG_UNITS_GAS);
        check(loop_ua, 16'd4000);
        rd(4'h0, 16'h0800);
        rd(4'h3, 16'h0000);
        check(dval, 12'h800);
        ticks(2000);
        check(msg, msm_pkg::MSG_READING);
        op.hold(0, 5);
        check(in_cal, 1'b0);
        sensor_faults <= 8'h05;
        rd(4'h1, 16'h0005);
        op.hold(1, 200);
        check(msg, msm_pkg::MSG_FAULT_LIST);
        ticks(2000);
        op.hold(0, 200);
        check(msg, msm_pkg::MSG_FAULT_LIST);
        check(in_cal, 1'b0);
        op.hold(0, 3100);
        check(msg, msm_pkg::MSG_CAL_PROMPT);
        check(loop_ua, 16'd2000);
        rd(4'h1, 16'h4005);
        ticks(4800);
        check(in_cal, 1'b1);
        ticks(200);
        check(in_cal, 1'b0);
        check(msg, msm_pkg::MSG_FAULT_DETECTED);
        check(loop_ua, 16'd4000);
        rd(4'h1, 16'h0005);
        op.hold(0, 3100);
        op.hold(1, 3100);
        check(span_act, 1'b1);
        check(loop_ua, 16'd2000);
        @(posedge clk);
        cal_fault_set <= 1'b1;
        @(posedge clk);
        cal_fault_set <= 1'b0;
        ticks(2);
        check(loop_ua, 16'd0);
        rd(4'h1, 16'h0105);
        wr(4'h2, 16'h0001);
        rd(4'h1, 16'h0005);
        check(loop_ua, 16'd4000);
        op.hold(0, 3100);
        op.hold(0, 3100);
        check(msg, msm_pkg::MSG_ZERO_CAL);
        ticks(4000);
        check(msg, msm_pkg::MSG_SETTING_ZERO);
        ticks(4000);
        check(msg, msm_pkg::MSG_ZERO_SAVED);
        ticks(4000);
        check(in_cal, 1'b0);
        fork
            op.hold(1, 3100);
            begin
                ticks(100);
                check(arrow_r, 1'b1);
                check(arrow_l, 1'b0);
            end
        join
        check(item, 3'h0);
        ticks(7800);
        check(item, 3'h3);
        check(msg, msm_pkg::MSG_MENU_ITEM);
        ticks(200);
        check(msg, msm_pkg::MSG_FAULT_DETECTED);
        op.hold(1, 3100);
        op.hold(0, 3100);
        check(msg, msm_pkg::MSG_EDIT_ITEM);
        ticks(3300);
        check(msg, msm_pkg::MSG_EDIT_ITEM);
        ticks(400);
        check(msg, msm_pkg::MSG_MENU_ITEM);
        wr(4'h2, 16'h0002);
        ticks(2);
        check(msg, msm_pkg::MSG_FAULT_DETECTED);
        wrap_up();
    end
endmodule : msm_ctrl_tb

bind msm_ctrl msm_ctrl_asserts #(.READ_W(READ_W), .TICK_CYCLES(TICK_CYCLES)) u_chk (
    .clk(clk), .reset(reset), .magnet_switch_left(magnet_switch_left), .reading(reading),
    .cal_fault_set(cal_fault_set), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_write(bus_write), .bus_read(bus_read), .bus_rdata(bus_rdata),
    .arrow_left(arrow_left), .display_msg(display_msg), .loop_ua(loop_ua),
    .in_calibration(in_calibration), .zero_cal_active(zero_cal_active),
    .span_cal_active(span_cal_active));
